// ==== logic/bst_tap.v ====
/*
 * Boundary-scan test access port: tap state machine, instruction
 * register and decode, bypass, identification and boundary registers.
 * Assumes the test pins come from an outside tester and are
 * oversampled by CLK (20 MHz); the test clock must be much slower.
 * Device pins and core signals are captured by the boundary cells; only the output pins are driven from them, under external test.
 */
// What this block does
// - low test reset forces Test-Logic-Reset at once
// - state advances per test clock rise, by tms
// - five tms-high clocks reach Test-Logic-Reset
// - reset state: normal operation, identification instruction
// - Capture-DR loads selected register's parallel value
// - Shift-DR shifts selected register toward lsb
// - Update-DR latches on falling clock, drives outputs
// - Capture-IR loads fixed pattern
// - Shift-IR shifts instruction, and bypass or id register when selected
// - Update-IR makes scanned code current, falling edge
// - pause states hold the shift path
// - each instruction selects exactly one data path
// - bypass: one-stage delay from tdi to tdo
// - external test: capture inputs, drive shifted outputs
// - sample: capture inputs and outputs for shifting
// - identification instruction shifts out id code
// - production test loads id code into boundary
// - data register clock only in capture/shift-dr
// - each cell has four-way two-select mux
`timescale 1ns/100ps
`include "bst_map.vh"

module bst_tap #(
  parameter N_IN = `BST_N_IN,
  parameter N_OUT = `BST_N_OUT,
  parameter [`BST_ID_W-1:0] ID_CODE = `BST_ID_DEFAULT
) (
  // system clock, reset, enable
  input wire CLK,
  input wire SRST,
  input wire CE,
  // test access pins
  input wire TCK,
  input wire TMS,
  input wire TDI,
  input wire TRST_N,
  output reg TDO,
  output reg TDO_OE,
  // device pins and core side
  input wire [N_IN-1:0] DEV_IN,
  output reg [N_IN-1:0] CORE_IN,
  input wire [N_OUT-1:0] CORE_OUT,
  output reg [N_OUT-1:0] DEV_OUT
);

  localparam BSR_LEN = N_IN + N_OUT;

  // tap states, one-hot
  localparam [15:0] S_TLR = 16'h0001;
  localparam [15:0] S_RTI = 16'h0002;
  localparam [15:0] S_SEL_DR = 16'h0004;
  localparam [15:0] S_CAP_DR = 16'h0008;
  localparam [15:0] S_SH_DR = 16'h0010;
  localparam [15:0] S_EX1_DR = 16'h0020;
  localparam [15:0] S_PAU_DR = 16'h0040;
  localparam [15:0] S_EX2_DR = 16'h0080;
  localparam [15:0] S_UPD_DR = 16'h0100;
  localparam [15:0] S_SEL_IR = 16'h0200;
  localparam [15:0] S_CAP_IR = 16'h0400;
  localparam [15:0] S_SH_IR = 16'h0800;
  localparam [15:0] S_EX1_IR = 16'h1000;
  localparam [15:0] S_PAU_IR = 16'h2000;
  localparam [15:0] S_EX2_IR = 16'h4000;
  localparam [15:0] S_UPD_IR = 16'h8000;

  // next tap state from current state and tms
  function [15:0] tap_next;
    input [15:0] st;
    input tms;
    begin
      case (st)
        S_TLR: tap_next = tms ? S_TLR : S_RTI;
        S_RTI: tap_next = tms ? S_SEL_DR : S_RTI;
        S_SEL_DR: tap_next = tms ? S_SEL_IR : S_CAP_DR;
        S_CAP_DR: tap_next = tms ? S_EX1_DR : S_SH_DR;
        S_SH_DR: tap_next = tms ? S_EX1_DR : S_SH_DR;
        S_EX1_DR: tap_next = tms ? S_UPD_DR : S_PAU_DR;
        S_PAU_DR: tap_next = tms ? S_EX2_DR : S_PAU_DR;
        S_EX2_DR: tap_next = tms ? S_UPD_DR : S_SH_DR;
        S_UPD_DR: tap_next = tms ? S_SEL_DR : S_RTI;
        S_SEL_IR: tap_next = tms ? S_TLR : S_CAP_IR;
        S_CAP_IR: tap_next = tms ? S_EX1_IR : S_SH_IR;
        S_SH_IR: tap_next = tms ? S_EX1_IR : S_SH_IR;
        S_EX1_IR: tap_next = tms ? S_UPD_IR : S_PAU_IR;
        S_PAU_IR: tap_next = tms ? S_EX2_IR : S_PAU_IR;
        S_EX2_IR: tap_next = tms ? S_UPD_IR : S_SH_IR;
        S_UPD_IR: tap_next = tms ? S_SEL_DR : S_RTI;
        default: tap_next = S_TLR;
      endcase
    end
  endfunction

  // pin synchronisers; third tck stage only for edge finding
  reg tck_s1, tck_s2, tck_s3;
  reg tms_s1, tms_s2;
  reg tdi_s1, tdi_s2;
  reg trst_n_s1, trst_n_s2;
  reg [N_IN-1:0] dev_in_s1;
  reg [N_IN-1:0] dev_in_s2;

  always @(posedge CLK) begin
    if (SRST) begin
      tck_s1 <= 1'b0;
      tck_s2 <= 1'b0;
      tck_s3 <= 1'b0;
      tms_s1 <= 1'b1;
      tms_s2 <= 1'b1;
      tdi_s1 <= 1'b1;
      tdi_s2 <= 1'b1;
      trst_n_s1 <= 1'b0;
      trst_n_s2 <= 1'b0;
      dev_in_s1 <= {N_IN{1'b0}};
      dev_in_s2 <= {N_IN{1'b0}};
    end else if (CE) begin
      tck_s1 <= TCK;
      tck_s2 <= tck_s1;
      tck_s3 <= tck_s2;
      tms_s1 <= TMS;
      tms_s2 <= tms_s1;
      tdi_s1 <= TDI;
      tdi_s2 <= tdi_s1;
      trst_n_s1 <= TRST_N;
      trst_n_s2 <= trst_n_s1;
      dev_in_s1 <= DEV_IN;
      dev_in_s2 <= dev_in_s1;
    end
  end

  wire tck_rise = tck_s2 & ~tck_s3;
  wire tck_fall = ~tck_s2 & tck_s3;
  wire trst_act = ~trst_n_s2;

  // tap state register
  reg [15:0] state;

  // test reset wins over any test clock edge, no edge needed
  always @(posedge CLK) begin
    if (SRST) begin
      state <= S_TLR;
    end else if (CE) begin
      if (trst_act) begin
        state <= S_TLR;
      end else if (tck_rise) begin
        state <= tap_next(state, tms_s2);
      end
    end
  end

  // instruction registers
  reg [`BST_IR_W-1:0] ir_shift;
  reg [`BST_IR_W-1:0] ir;

  // decode; unknown codes fall to bypass so one path is always chosen
  wire op_ext = (ir == `BST_OP_EXTEST);
  wire op_smp = (ir == `BST_OP_SAMPLE);
  wire op_id = (ir == `BST_OP_IDCODE);
  wire op_prod = (ir == `BST_OP_PRODTEST);
  wire sel_bsr = op_ext | op_smp | op_prod;
  wire sel_byp = ~sel_bsr & ~op_id;

  always @(posedge CLK) begin
    if (SRST) begin
      ir_shift <= `BST_IR_CAPTURE;
      ir <= `BST_OP_IDCODE;
    end else if (CE) begin
      if (state == S_TLR) begin
        ir <= `BST_OP_IDCODE;
      end else if (tck_fall && state == S_UPD_IR) begin
        ir <= ir_shift;
      end
      if (tck_rise && state == S_CAP_IR) begin
        ir_shift <= `BST_IR_CAPTURE;
      end else if (tck_rise && state == S_SH_IR) begin
        ir_shift <= {tdi_s2, ir_shift[`BST_IR_W-1:1]};
      end
    end
  end

  // bypass and id registers; pause and exit states leave them alone
  reg byp;
  reg [`BST_ID_W-1:0] idr;
  wire cap_dr = tck_rise && state == S_CAP_DR;
  wire sh_dr = tck_rise && state == S_SH_DR;
  wire sh_ir = tck_rise && state == S_SH_IR;

  always @(posedge CLK) begin
    if (SRST) begin
      byp <= 1'b0;
      idr <= ID_CODE;
    end else if (CE) begin
      if (sel_byp && cap_dr) begin
        byp <= 1'b0;
      end else if (sel_byp && (sh_dr || sh_ir)) begin
        byp <= tdi_s2;
      end
      if (op_id && cap_dr) begin
        idr <= ID_CODE;
      end else if (op_id && (sh_dr || sh_ir)) begin
        idr <= {tdi_s2, idr[`BST_ID_W-1:1]};
      end
    end
  end

  // data register clock for the cells, only in capture/shift-dr
  wire clock_dr = sel_bsr & (cap_dr | sh_dr);
  // capture picks input pins and core outputs, or the id bit under production test
  wire cell_select_low = (state == S_CAP_DR);
  wire cell_select_high = (state == S_SH_DR) | op_prod;
  // update only under the instructions that use the latches
  wire upd_en = tck_fall & (state == S_UPD_DR) & (op_ext | op_smp);

  // boundary chain; cell 0 sits next to tdo
  wire [BSR_LEN-1:0] bsr_q;
  wire [BSR_LEN-1:0] bsr_upd;
  wire [BSR_LEN-1:0] bsr_par = {CORE_OUT, dev_in_s2};

  genvar gi;
  generate
    for (gi = 0; gi < BSR_LEN; gi = gi + 1) begin : g_cell
      wire sin;
      if (gi == BSR_LEN - 1) begin : g_head
        assign sin = tdi_s2;
      end else begin : g_link
        assign sin = bsr_q[gi+1];
      end
      bst_cell #(
        .HAS_UPDATE(gi >= N_IN ? 1 : 0)
      ) u_cell (
        .clk(CLK),
        .srst(SRST),
        .ce(CE),
        .clock_dr(clock_dr),
        .cell_select_low(cell_select_low),
        .cell_select_high(cell_select_high),
        .update_en(upd_en),
        .parallel_in(bsr_par[gi]),
        .scan_in(sin),
        .id_bit(ID_CODE[gi % `BST_ID_W]),
        .scan_out(bsr_q[gi]),
        .update_q(bsr_upd[gi])
      );
    end
  endgenerate

  // selected serial path, exactly one per instruction
  reg dr_out;
  always @* begin
    if (sel_bsr) begin
      dr_out = bsr_q[0];
    end else if (op_id) begin
      dr_out = idr[0];
    end else begin
      dr_out = byp;
    end
  end

  // tdo moves on the falling edge; the tester samples it at the end of the high phase
  always @(posedge CLK) begin
    if (SRST) begin
      TDO <= 1'b1;
      TDO_OE <= 1'b0;
    end else if (CE) begin
      if (trst_act) begin
        TDO_OE <= 1'b0;
      end else if (tck_fall) begin
        if (state == S_SH_DR) begin
          TDO <= dr_out;
          TDO_OE <= 1'b1;
        end else if (state == S_SH_IR) begin
          TDO <= ir_shift[0];
          TDO_OE <= 1'b1;
        end else begin
          TDO_OE <= 1'b0;
        end
      end
    end
  end

  // pin side: latches take the outputs only under external test
  always @(posedge CLK) begin
    if (SRST) begin
      CORE_IN <= {N_IN{1'b0}};
      DEV_OUT <= {N_OUT{1'b0}};
    end else if (CE) begin
      CORE_IN <= dev_in_s2;
      if (op_ext) begin
        DEV_OUT <= bsr_upd[BSR_LEN-1:N_IN];
      end else begin
        DEV_OUT <= CORE_OUT;
      end
    end
  end

endmodule // bst_tap

// ==== logic/bst_map.vh ====
/*
 * Constants of the boundary-scan test access port: instruction
 * opcodes, capture patterns, scan-cell mux codes and the default
 * identification code.
 * Assumes it is included by bare name before any module that uses it.
 */
`ifndef BST_MAP_VH
`define BST_MAP_VH

// instruction register width and opcodes; all ones is bypass
`define BST_IR_W 3
`define BST_OP_EXTEST 3'h0
`define BST_OP_SAMPLE 3'h1
`define BST_OP_IDCODE 3'h2
`define BST_OP_PRODTEST 3'h4
`define BST_OP_BYPASS 3'h7

// fixed pattern loaded in capture-ir, low bits 01 as usual
`define BST_IR_CAPTURE 3'h1

// identification code; the value is arbitrary, lsb must be 1
`define BST_ID_W 32
`define BST_ID_DEFAULT 32'h0A5C3001

// central cell mux codes {cell_select_high, cell_select_low}
`define BST_SEL_HOLD 2'h0
`define BST_SEL_CAPTURE 2'h1
`define BST_SEL_SHIFT 2'h2
`define BST_SEL_IDBIT 2'h3

// boundary chain sizes
`define BST_N_IN 8
`define BST_N_OUT 8

`endif

// ==== logic/bst_cell.v ====
/*
 * One boundary scan cell: capture/shift stage behind a four-way
 * mux, plus an optional parallel update latch.
 * Assumes clock_dr and update_en are one-cycle enables on clk.
 */
`timescale 1ns/100ps
`include "bst_map.vh"

module bst_cell #(
  parameter HAS_UPDATE = 1
) (
  // clock, reset, enable
  input wire clk,
  input wire srst,
  input wire ce,
  // control from the tap
  input wire clock_dr,
  input wire cell_select_low,
  input wire cell_select_high,
  input wire update_en,
  // data
  input wire parallel_in,
  input wire scan_in,
  input wire id_bit,
  output reg scan_out,
  output reg update_q
);

  reg next_scan;

  // central four-input mux on the two select lines
  always @* begin
    case ({cell_select_high, cell_select_low})
      `BST_SEL_CAPTURE: next_scan = parallel_in;
      `BST_SEL_SHIFT: next_scan = scan_in;
      `BST_SEL_IDBIT: next_scan = id_bit;
      default: next_scan = scan_out;
    endcase
  end

  // stage only moves while clock_dr is active
  always @(posedge clk) begin
    if (srst) begin
      scan_out <= 1'b0;
    end else if (ce && clock_dr) begin
      scan_out <= next_scan;
    end
  end

  // update latch; input cells build none
  always @(posedge clk) begin
    if (srst || HAS_UPDATE == 0) begin
      update_q <= 1'b0;
    end else if (ce && update_en) begin
      update_q <= scan_out;
    end
  end

endmodule // bst_cell

// ==== bench/bst_tester.sv ====
/* tester model: drives the test pins and reads the test data line.
   assumes CLK at 20 MHz and a pulled-up test data line */
`timescale 1ns/100ps
module bst_tester (
  // clock
  input wire CLK,
  // test pins
  output reg TCK,
  output reg TMS,
  output reg TDI,
  input wire TDO,
  input wire TDO_OE
);
  // released line reads the pull-up, never the last bit
  wire tdo_line = TDO_OE ? TDO : 1'b1;
  // tck rests low between frames
  initial begin
    TCK = 1'b0;
    TMS = 1'b1;
    TDI = 1'b0;
  end
  // one 400 ns test clock; call just after a CLK rise
  task step(input logic m, input logic d, output logic q);
    TMS = m;
    TDI = d;
    repeat (4) @(posedge CLK);
    #2 TCK = 1'b1;
    repeat (4) @(posedge CLK);
    #2 q = tdo_line;
    TCK = 1'b0;
  endtask
  // from idle: scan n bits lsb first, optional pause after bit pz
  task scan(input logic ir, input int n, input logic [31:0] din, input int pz,
    output logic [31:0] dout);
    logic q;
    int i;
    dout = '0;
    step(1'b1, 1'b0, q);
    if (ir) begin
      step(1'b1, 1'b0, q);
    end
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (i = 0; i < n; i++) begin
      step(i == n - 1 || i == pz, din[i], q);
      dout[i] = q;
      if (i == pz) begin
        // rest in pause, then come back to shift
        step(1'b0, 1'b0, q);
        step(1'b0, 1'b0, q);
        step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
      end
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
endmodule // bst_tester

// ==== bench/bst_tap_sva.sv ====
/* checker of the test access port on its top ports.
   assumes tck phases of at least 4 system clocks */
`timescale 1ns/100ps
module bst_tap_sva #(
  parameter N_IN = 8,
  parameter N_OUT = 8
) (
  // system side
  input wire CLK,
  input wire SRST,
  input wire CE,
  // test pins
  input wire TCK,
  input wire TMS,
  input wire TDI,
  input wire TRST_N,
  input wire TDO,
  input wire TDO_OE,
  // device and core
  input wire [N_IN-1:0] DEV_IN,
  input wire [N_IN-1:0] CORE_IN,
  input wire [N_OUT-1:0] CORE_OUT,
  input wire [N_OUT-1:0] DEV_OUT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  // outputs quiet right after reset
  a_reset_quiet: assert property ($fell(SRST) |-> TDO && !TDO_OE && CORE_IN == '0
    && DEV_OUT == '0) else $error("outputs not quiet after reset");
  a_tdo_on_fall: assert property ($changed(TDO) |-> !TCK)
    else $error("tdo moved while tck high");
  a_tdo_only_shift: assert property ($changed(TDO) |-> TDO_OE || $past(TDO_OE))
    else $error("tdo moved while released");
  a_oe_rise_fall: assert property ($rose(TDO_OE) |-> !TCK && !$past(TCK, 2))
    else $error("tdo enabled off a falling edge");
  a_oe_drop_fall: assert property ($fell(TDO_OE) |-> !TCK)
    else $error("tdo released while tck high");
  a_trst_release: assert property ($fell(TRST_N) |-> ##[1:4] !TDO_OE)
    else $error("test reset left tdo driven");
  a_trst_normal: assert property (!TRST_N [*6] |-> DEV_OUT == $past(CORE_OUT))
    else $error("pins not in normal use under test reset");
  a_core_follow: assert property (CORE_IN == $past(DEV_IN, 3))
    else $error("core input does not follow pins");
  // main scenarios reached
  c_shift: cover property ($rose(TDO_OE));
  c_trst: cover property ($fell(TRST_N));
  c_extest: cover property (DEV_OUT != $past(CORE_OUT));
endmodule // bst_tap_sva

bind bst_tap bst_tap_sva #(.N_IN(N_IN), .N_OUT(N_OUT)) i_sva (.CLK(CLK), .SRST(SRST),
  .CE(CE), .TCK(TCK), .TMS(TMS), .TDI(TDI), .TRST_N(TRST_N), .TDO(TDO), .TDO_OE(TDO_OE),
  .DEV_IN(DEV_IN), .CORE_IN(CORE_IN), .CORE_OUT(CORE_OUT), .DEV_OUT(DEV_OUT));

// ==== bench/boundary_scan_tap_bench.sv ====
/* testbench of the test access port with the tester model.
   assumes default sizes: 8 inputs, 8 outputs, 3-bit opcodes */
`timescale 1ns/100ps
`include "bst_map.vh"
module boundary_scan_tap_bench;
  localparam logic [31:0] ID = `BST_ID_DEFAULT;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic trst_n = 1'b1;
  logic ce = 1'b1;
  logic [7:0] dev_in = 8'h00;
  logic [7:0] core_out = 8'h00;
  wire tck, tms, tdi, tdo, tdo_oe;
  wire [7:0] core_in, dev_out;
  int bad_count = 0;
  int num_checks = 0;
  logic [31:0] got;
  logic q;
  int i;
  // 20 MHz clock
  always #25 clk = ~clk;
  bst_tap i_dut (.CLK(clk), .SRST(srst), .CE(ce), .TCK(tck), .TMS(tms), .TDI(tdi),
    .TRST_N(trst_n), .TDO(tdo), .TDO_OE(tdo_oe), .DEV_IN(dev_in), .CORE_IN(core_in),
    .CORE_OUT(core_out), .DEV_OUT(dev_out));
  bst_tester i_tester (.CLK(clk), .TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo),
    .TDO_OE(tdo_oe));
  // compare, count, report
  task chk(input logic [31:0] act, input logic [31:0] exp);
    num_checks++;
    if (act !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, act, exp);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task set_ir(input logic [2:0] op);
    i_tester.scan(1'b1, 3, {29'h0, op}, -1, got);
    chk(got & 32'h7, `BST_IR_CAPTURE);
  endtask
  task t_idcode;
    // reset leaves the tap in test-logic-reset; scan starts from idle
    i_tester.step(1'b0, 1'b0, q);
    i_tester.scan(1'b0, 32, 32'h0, 12, got);
    chk(got, ID);
    chk({31'h0, tdo_oe}, 32'h0);
  endtask
  task t_bypass(input logic [2:0] op);
    set_ir(op);
    i_tester.scan(1'b0, 8, 32'hB4, -1, got);
    chk(got & 32'hFF, 32'h68);
  endtask
  task t_extest;
    dev_in = 8'h5A;
    core_out = 8'h66;
    set_ir(`BST_OP_EXTEST);
    i_tester.scan(1'b0, 16, 32'hC300, -1, got);
    chk(got & 32'hFF, 32'h5A);
    chk({24'h0, dev_out}, 32'hC3);
    chk({24'h0, core_in}, 32'h5A);
  endtask
  task t_sample;
    dev_in = 8'h27;
    core_out = 8'h9C;
    set_ir(`BST_OP_SAMPLE);
    i_tester.scan(1'b0, 16, 32'h0, -1, got);
    chk(got & 32'hFFFF, 32'h9C27);
    chk({24'h0, dev_out}, 32'h9C);
  endtask
  task t_prod;
    set_ir(`BST_OP_PRODTEST);
    i_tester.scan(1'b0, 16, 32'h0, -1, got);
    chk(got & 32'hFFFF, ID & 32'hFFFF);
  endtask
  // tms escape from shift-dr, then the test reset pin
  task t_resets;
    set_ir(`BST_OP_BYPASS);
    for (i = 0; i < 9; i++) begin
      i_tester.step(i != 1 && i != 2 && i != 8, 1'b0, q);
    end
    i_tester.scan(1'b0, 32, 32'h0, -1, got);
    chk(got, ID);
    set_ir(`BST_OP_BYPASS);
    // enable low freezes the synchronisers, so this reset pulse is lost
    ce = 1'b0;
    trst_n = 1'b0;
    repeat (6) @(posedge clk);
    #2 trst_n = 1'b1;
    repeat (6) @(posedge clk);
    #2 ce = 1'b1;
    repeat (2) @(posedge clk);
    #2 i_tester.scan(1'b0, 8, 32'hB4, -1, got);
    chk(got & 32'hFF, 32'h68);
    // reset under external test must give the pins back to the core
    set_ir(`BST_OP_EXTEST);
    chk({24'h0, dev_out}, 32'h00);
    trst_n = 1'b0;
    repeat (6) @(posedge clk);
    #2 trst_n = 1'b1;
    chk({24'h0, dev_out}, {24'h0, core_out});
    repeat (6) @(posedge clk);
    #2 i_tester.step(1'b0, 1'b0, q);
    i_tester.scan(1'b0, 32, 32'h0, -1, got);
    chk(got, ID);
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    #2 srst = 1'b0;
    repeat (6) @(posedge clk);
    #2 t_idcode();
    t_bypass(`BST_OP_BYPASS);
    t_bypass(3'h3);
    t_extest();
    t_sample();
    t_prod();
    t_resets();
    finish_test();
  end
  // watchdog: the run needs about 120 us
  initial begin
    #1000000;
    bad_count++;
    finish_test();
  end
endmodule // boundary_scan_tap_bench
